// ==== rtl/riap_cfg.svh ====
/*
 * Constants of the indirect access port: SFR offsets, key codes,
 * interface state codes, field positions and access lengths.
 * Assumes it is included by bare name from the rtl/ files.
 */
`ifndef RIAP_CFG_SVH
`define RIAP_CFG_SVH

// ************************************************************
// SFR offsets
// ************************************************************
`define RIAP_OFS_ADDR       8'hac
`define RIAP_OFS_DATA       8'had
`define RIAP_OFS_KEY        8'hae

// ************************************************************
// Key codes and state codes seen when reading the key register
// ************************************************************
`define RIAP_KEY_FIRST      8'ha5
`define RIAP_KEY_SECOND     8'hf1
`define RIAP_CODE_LOCKED    8'h00
`define RIAP_CODE_FIRST     8'h01
`define RIAP_CODE_UNLOCKED  8'h02
`define RIAP_CODE_DISABLED  8'h03

// ************************************************************
// Address register fields and reset values
// ************************************************************
`define RIAP_BIT_BUSY       7
`define RIAP_BIT_AUTO       6
`define RIAP_BIT_SHORT      4
`define RIAP_ADDR_MSB       3
`define RIAP_ADDR_RESET     4'h0
`define RIAP_DATA_RESET     8'h00
`define RIAP_READ_ZERO      8'h00

// ************************************************************
// Internal registers that auto-increment the address field
// ************************************************************
`define RIAP_SNAP_FIRST     4'h0
`define RIAP_SNAP_LAST      4'h3
`define RIAP_MATCH_FIRST    4'h8
`define RIAP_MATCH_LAST     4'hb
`define RIAP_ADDR_STEP      4'h1

// ************************************************************
// Access length in system clock cycles
// ************************************************************
`define RIAP_NORMAL_CYCLES  7
`define RIAP_SHORT_CYCLES   6

`endif

// ==== rtl/riap_pkg.sv ====
/*
 * Types shared by the indirect access port files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package riap_pkg;

    // Gray order along locked -> first key -> unlocked
    typedef enum logic [1:0] {
        RIAP_LOCKED   = 2'h0,
        RIAP_KEY_SEEN = 2'h1,
        RIAP_UNLOCKED = 2'h3,
        RIAP_DISABLED = 2'h2
    } riap_lock_t;

endpackage

`default_nettype wire

// ==== rtl/riap_access_timer.sv ====
/*
 * Down counter that times one indirect access.
 * Assumes start_in is only raised while busy_out is low.
 */
`include "riap_cfg.svh"
`default_nettype none

module riap_access_timer #(
    parameter int unsigned NORMAL_CYCLES = `RIAP_NORMAL_CYCLES,
    parameter int unsigned SHORT_CYCLES  = `RIAP_SHORT_CYCLES,
    parameter int unsigned CNT_W         = 3
) (
    input  wire logic clock_in,
    input  wire logic resetn_in,
    input  wire logic start_in,
    input  wire logic short_in,
    output logic      busy_out,
    output logic      last_out
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (start_in) begin
            next_count = short_in ? CNT_W'(SHORT_CYCLES)
                                  : CNT_W'(NORMAL_CYCLES);
        end else if (count != '0) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign busy_out = (count != '0);
    assign last_out = (count == CNT_W'(1));
endmodule

`default_nettype wire

// ==== rtl/riap_indirect_port.sv ====
/*
 * Indirect access port between the processor SFR bus and the
 * real-time clock's internal register set: lock-and-key machine,
 * address register with busy, auto-read and reduced strobe, and
 * the data port.
 * Assumes the SFR bus and the clock core share clock_in, and that
 * the core presents read data combinationally for rtc_addr_out.
 */
`include "riap_cfg.svh"
`default_nettype none

module riap_indirect_port
    import riap_pkg::*;
#(
    parameter int unsigned NORMAL_CYCLES = `RIAP_NORMAL_CYCLES,
    parameter int unsigned SHORT_CYCLES  = `RIAP_SHORT_CYCLES
) (
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    output logic      [3:0] rtc_addr_out,
    output logic      [7:0] rtc_wdata_out,
    output logic            rtc_wr_stb_out,
    output logic            rtc_rd_stb_out,
    input  wire logic [7:0] rtc_rdata_in
);
    // ************************************************************
    // State
    // ************************************************************
    riap_lock_t lock_state;
    riap_lock_t next_lock_state;
    logic       auto_read;
    logic       next_auto_read;
    logic       short_strobe;
    logic       next_short_strobe;
    logic [3:0] addr_field;
    logic [3:0] next_addr_field;
    logic [7:0] data_port;
    logic [7:0] next_data_port;
    logic       acc_write;
    logic       next_acc_write;
    logic [7:0] rdata;
    logic [7:0] next_rdata;

    logic       start;
    logic       busy;
    logic       last;

    // ************************************************************
    // Decode of SFR accesses
    // ************************************************************
    logic key_wr;
    logic adr_wr;
    logic dat_wr;
    logic dat_rd;
    logic unlocked;
    logic attempt;
    logic auto_inc;

    assign key_wr   = sfr_wr_in && (sfr_addr_in == `RIAP_OFS_KEY);
    assign adr_wr   = sfr_wr_in && (sfr_addr_in == `RIAP_OFS_ADDR);
    assign dat_wr   = sfr_wr_in && (sfr_addr_in == `RIAP_OFS_DATA);
    assign dat_rd   = sfr_rd_in && (sfr_addr_in == `RIAP_OFS_DATA);
    assign unlocked = (lock_state == RIAP_UNLOCKED);

    // Anything that would start an indirect transfer
    assign attempt = (adr_wr && sfr_wdata_in[`RIAP_BIT_BUSY])
                   || dat_wr
                   || (dat_rd && auto_read);

    // Snapshot bytes start at index zero, so no lower bound
    assign auto_inc =
        (addr_field <= `RIAP_SNAP_LAST)
        || ((addr_field >= `RIAP_MATCH_FIRST)
            && (addr_field <= `RIAP_MATCH_LAST));

    // ************************************************************
    // Lock and key machine
    // ************************************************************
    always_comb begin
        next_lock_state = lock_state;
        case (lock_state)
            RIAP_LOCKED: begin
                if (key_wr) begin
                    if (sfr_wdata_in == `RIAP_KEY_FIRST) begin
                        next_lock_state = RIAP_KEY_SEEN;
                    end else begin
                        next_lock_state = RIAP_DISABLED;
                    end
                end else if (attempt) begin
                    next_lock_state = RIAP_DISABLED;
                end
            end
            RIAP_KEY_SEEN: begin
                if (key_wr) begin
                    if (sfr_wdata_in == `RIAP_KEY_SECOND) begin
                        next_lock_state = RIAP_UNLOCKED;
                    end else begin
                        next_lock_state = RIAP_DISABLED;
                    end
                end else if (attempt) begin
                    next_lock_state = RIAP_DISABLED;
                end
            end
            RIAP_UNLOCKED: begin
                if (key_wr) begin
                    next_lock_state = RIAP_LOCKED;
                end
            end
            RIAP_DISABLED: begin
                next_lock_state = RIAP_DISABLED;
            end
            default: begin
                next_lock_state = RIAP_DISABLED;
            end
        endcase
    end

    // ************************************************************
    // Address register, data port and access launch
    // ************************************************************
    always_comb begin
        next_auto_read    = auto_read;
        next_short_strobe = short_strobe;
        next_addr_field   = addr_field;
        next_data_port    = data_port;
        next_acc_write    = acc_write;
        start             = 1'b0;
        // Writes during an access are dropped so the target and
        // data stay stable until the strobe
        if (unlocked && !busy) begin
            if (adr_wr) begin
                next_auto_read    = sfr_wdata_in[`RIAP_BIT_AUTO];
                next_short_strobe = sfr_wdata_in[`RIAP_BIT_SHORT];
                next_addr_field   = sfr_wdata_in[`RIAP_ADDR_MSB:0];
                if (sfr_wdata_in[`RIAP_BIT_BUSY]) begin
                    start          = 1'b1;
                    next_acc_write = 1'b0;
                end
            end else if (dat_wr) begin
                next_data_port = sfr_wdata_in;
                start          = 1'b1;
                next_acc_write = 1'b1;
            end else if (dat_rd && auto_read) begin
                start          = 1'b1;
                next_acc_write = 1'b0;
            end
        end
        if (last) begin
            if (!acc_write) begin
                next_data_port = rtc_rdata_in;
            end
            if (auto_inc) begin
                next_addr_field = addr_field + `RIAP_ADDR_STEP;
            end
        end
    end

    // ************************************************************
    // Read-back; locked port answers zero except the key register
    // ************************************************************
    always_comb begin
        next_rdata = rdata;
        if (sfr_rd_in) begin
            next_rdata = `RIAP_READ_ZERO;
            if (sfr_addr_in == `RIAP_OFS_KEY) begin
                case (lock_state)
                    RIAP_LOCKED:   next_rdata = `RIAP_CODE_LOCKED;
                    RIAP_KEY_SEEN: next_rdata = `RIAP_CODE_FIRST;
                    RIAP_UNLOCKED: next_rdata = `RIAP_CODE_UNLOCKED;
                    RIAP_DISABLED: next_rdata = `RIAP_CODE_DISABLED;
                    default:       next_rdata = `RIAP_CODE_DISABLED;
                endcase
            end else if (unlocked
                         && (sfr_addr_in == `RIAP_OFS_ADDR)) begin
                next_rdata[`RIAP_BIT_BUSY]  = busy;
                next_rdata[`RIAP_BIT_AUTO]  = auto_read;
                next_rdata[`RIAP_BIT_SHORT] = short_strobe;
                next_rdata[`RIAP_ADDR_MSB:0] = addr_field;
            end else if (unlocked
                         && (sfr_addr_in == `RIAP_OFS_DATA)) begin
                next_rdata = data_port;
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lock_state   <= RIAP_LOCKED;
            auto_read    <= 1'b0;
            short_strobe <= 1'b0;
            addr_field   <= `RIAP_ADDR_RESET;
            data_port    <= `RIAP_DATA_RESET;
            acc_write    <= 1'b0;
            rdata        <= `RIAP_READ_ZERO;
        end else begin
            lock_state   <= next_lock_state;
            auto_read    <= next_auto_read;
            short_strobe <= next_short_strobe;
            addr_field   <= next_addr_field;
            data_port    <= next_data_port;
            acc_write    <= next_acc_write;
            rdata        <= next_rdata;
        end
    end

    // ************************************************************
    // Access timing
    // ************************************************************
    // Reduced timing is latched with the start, so a later change
    // of the bit never stretches a running access
    riap_access_timer #(
        .NORMAL_CYCLES (NORMAL_CYCLES),
        .SHORT_CYCLES  (SHORT_CYCLES)
    ) u_timer (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .start_in  (start),
        .short_in  (next_short_strobe),
        .busy_out  (busy),
        .last_out  (last)
    );

    // Strobe in the final cycle; core data must be valid then
    assign rtc_wr_stb_out = last && acc_write;
    assign rtc_rd_stb_out = last && !acc_write;
    assign rtc_addr_out   = addr_field;
    assign rtc_wdata_out  = data_port;
    assign sfr_rdata_out  = rdata;
endmodule

`default_nettype wire

// ==== test/riap_port_chk.sv ====
/* Port checker for the indirect access port.
 * Assumes it is bound to riap_indirect_port, one clock domain. */
`default_nettype none
module riap_port_chk #(
    parameter int unsigned NORMAL_CYCLES = 7,
    parameter int unsigned SHORT_CYCLES  = 6
) (
    input  wire logic       clock_in,
    input  wire logic       resetn_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    input  wire logic [7:0] sfr_rdata_out,
    input  wire logic [3:0] rtc_addr_out,
    input  wire logic [7:0] rtc_wdata_out,
    input  wire logic       rtc_wr_stb_out,
    input  wire logic       rtc_rd_stb_out,
    input  wire logic [7:0] rtc_rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ********
    // Helpers
    // ********
    logic dat_wr;
    logic rd_go;
    logic stb;
    logic step;
    assign dat_wr = sfr_wr_in && sfr_addr_in == 8'had;
    assign rd_go = (sfr_wr_in && sfr_addr_in == 8'hac && sfr_wdata_in[7])
        || (sfr_rd_in && sfr_addr_in == 8'had);
    assign stb = rtc_wr_stb_out || rtc_rd_stb_out;
    assign step = rtc_addr_out <= 4'h3
        || (rtc_addr_out >= 4'h8 && rtc_addr_out <= 4'hb);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_fetch;
        rtc_rd_stb_out ##1 (sfr_rd_in && sfr_addr_in == 8'had);
    endsequence
    // ********
    // Rules
    // ********
    a_key_code: assert property (
        sfr_rd_in && sfr_addr_in == 8'hae |=> sfr_rdata_out <= 8'h03)
        else $error("key status out of range");
    a_bit5_zero: assert property (
        sfr_rd_in && sfr_addr_in == 8'hac |=> !sfr_rdata_out[5])
        else $error("address bit 5 not zero");
    a_stb_single: assert property (
        stb |=> !rtc_wr_stb_out && !rtc_rd_stb_out)
        else $error("strobe longer than one cycle");
    a_wr_cause: assert property (
        rtc_wr_stb_out |-> $past(dat_wr, NORMAL_CYCLES)
        || $past(dat_wr, SHORT_CYCLES))
        else $error("write strobe without timed cause");
    a_rd_cause: assert property (
        rtc_rd_stb_out |-> $past(rd_go, NORMAL_CYCLES)
        || $past(rd_go, SHORT_CYCLES))
        else $error("read strobe without timed cause");
    a_fetch_data: assert property (
        s_fetch |=> sfr_rdata_out == $past(rtc_rdata_in, 2))
        else $error("data port missed core byte");
    a_addr_step: assert property (
        stb && step |=> rtc_addr_out == $past(rtc_addr_out) + 4'h1)
        else $error("address not incremented");
    a_addr_hold: assert property (
        stb && !step |=> $stable(rtc_addr_out))
        else $error("address moved");
    a_access_stable: assert property (
        stb |-> $stable(rtc_addr_out) && $stable(rtc_wdata_out))
        else $error("target changed during access");
endmodule
bind riap_indirect_port riap_port_chk #(
    .NORMAL_CYCLES(NORMAL_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)
) chk_u (.clock_in(clock_in), .resetn_in(resetn_in),
    .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
    .sfr_rdata_out(sfr_rdata_out), .rtc_addr_out(rtc_addr_out),
    .rtc_wdata_out(rtc_wdata_out), .rtc_wr_stb_out(rtc_wr_stb_out),
    .rtc_rd_stb_out(rtc_rd_stb_out), .rtc_rdata_in(rtc_rdata_in));
`default_nettype wire

// ==== test/riap_core_model.sv ====
/* Model of the clock core's sixteen internal byte registers.
 * Assumes the port's strobes and address, same clock. */
`default_nettype none
module riap_core_model (
    input  wire logic       clock_in,
    input  wire logic [3:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_stb_in,
    output logic      [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [16];
    // Distinct contents so a wrong index shows
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 8'hc0 + 8'(i);
        end
    end
    assign rdata_out = mem[addr_in];
    always @(posedge clock_in) begin
        if (wr_stb_in === 1'b1) begin
            mem[addr_in] <= wdata_in;
        end
    end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
/* Self-checking bench for the indirect access port.
 * Assumes the core model and checker files are compiled first. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NC = 7;
    localparam int SC = 6;
    localparam logic [7:0] AC = 8'hac;
    localparam logic [7:0] AD = 8'had;
    localparam logic [7:0] AE = 8'hae;
    logic       clock_in;
    logic       resetn_in;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic [3:0] rtc_addr;
    logic [7:0] rtc_wdata;
    logic       rtc_wr_stb;
    logic       rtc_rd_stb;
    logic [7:0] rtc_rdata;
    int         fails;
    int         cmp_count;
    int         cyc;
    riap_indirect_port #(.NORMAL_CYCLES(NC), .SHORT_CYCLES(SC)) dut_u (
        .clock_in(clock_in), .resetn_in(resetn_in),
        .sfr_addr_in(sfr_addr), .sfr_wr_in(sfr_wr), .sfr_rd_in(sfr_rd),
        .sfr_wdata_in(sfr_wdata), .sfr_rdata_out(sfr_rdata),
        .rtc_addr_out(rtc_addr), .rtc_wdata_out(rtc_wdata),
        .rtc_wr_stb_out(rtc_wr_stb), .rtc_rd_stb_out(rtc_rd_stb),
        .rtc_rdata_in(rtc_rdata));
    riap_core_model core_u (.clock_in(clock_in), .addr_in(rtc_addr),
        .wdata_in(rtc_wdata), .wr_stb_in(rtc_wr_stb),
        .rdata_out(rtc_rdata));
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    // ********
    // Tasks
    // ********
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clock_in);
        sfr_wr = 1'b0;
    endtask
    // One read per data access: no read-modify-write
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock_in);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clock_in);
        sfr_rd = 1'b0;
        chk(sfr_rdata, e);
    endtask
    // Counts cycles from now to the strobe, bounded
    task automatic wait_stb(input logic [7:0] e);
        int n;
        n = 1;
        while ((rtc_wr_stb | rtc_rd_stb) !== 1'b1 && n < 20) begin
            @(negedge clock_in);
            n++;
        end
        chk(8'(n), e);
    endtask
    task automatic rst();
        resetn_in = 1'b0;
        repeat (3) @(negedge clock_in);
        resetn_in = 1'b1;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            print_verdict();
        end
    end
    // ********
    // Sequence
    // ********
    initial begin
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;
        {fails, cmp_count, cyc} = '0;
        rst();
        rd(AC, 8'h00);
        rd(AD, 8'h00);
        rd(AE, 8'h00);
        wr(AE, 8'ha5);
        rd(AE, 8'h01);
        wr(AE, 8'hf1);
        rd(AE, 8'h02);
        wr(AC, 8'h7a);
        rd(AC, 8'h5a);
        $display("test 1 done");
        wr(AC, 8'h02);
        wr(AD, 8'h3c);
        wait_stb(8'(NC));
        // Core takes the byte at the edge that closes the strobe
        @(negedge clock_in);
        chk(core_u.mem[2], 8'h3c);
        rd(AC, 8'h03);
        wr(AC, 8'h92);
        wait_stb(8'(SC));
        rd(AD, 8'h3c);
        rd(AC, 8'h13);
        $display("test 2 done");
        wr(AC, 8'h05);
        wr(AD, 8'h77);
        rd(AC, 8'h85);
        wait_stb(8'(NC - 2));
        rd(AC, 8'h05);
        $display("test 3 done");
        wr(AC, 8'hdb);
        wait_stb(8'(SC));
        rd(AD, 8'hcb);
        wait_stb(8'(SC));
        rd(AD, 8'hcc);
        wait_stb(8'(SC));
        rd(AC, 8'h5c);
        $display("test 4 done");
        wr(AE, 8'h00);
        rd(AE, 8'h00);
        wr(AD, 8'h11);
        rd(AE, 8'h03);
        wr(AE, 8'ha5);
        rd(AE, 8'h03);
        rd(AC, 8'h00);
        $display("test 5 done");
        rst();
        wr(AE, 8'ha5);
        wr(AE, 8'h12);
        rd(AE, 8'h03);
        wr(AE, 8'hf1);
        rd(AE, 8'h03);
        $display("test 6 done");
        print_verdict();
    end
endmodule
`default_nettype wire
